// ==== rtl/cpu_decode_pkg.sv ====
`default_nettype none
package cpu_decode_pkg;

	localparam logic [3:0]  REG_PC    = 4'h0;
	localparam logic [3:0]  REG_SR    = 4'h2;
	localparam logic [3:0]  REG_CG    = 4'h3;
	localparam int unsigned REG_COUNT = 16;

	localparam logic [1:0]  MODE_REG  = 2'h0;
	localparam logic [1:0]  MODE_IDX  = 2'h1;
	localparam logic [1:0]  MODE_IND  = 2'h2;
	localparam logic [1:0]  MODE_AUTO = 2'h3;

	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] RESET_PC  = 16'h0000;
	localparam logic [15:0] BYTE_MASK = 16'h00FF;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	localparam logic [15:0] CG_ZERO   = 16'h0000;
	localparam logic [15:0] CG_ONE    = 16'h0001;
	localparam logic [15:0] CG_TWO    = 16'h0002;
	localparam logic [15:0] CG_FOUR   = 16'h0004;
	localparam logic [15:0] CG_EIGHT  = 16'h0008;
	localparam logic [15:0] CG_ALL    = 16'hFFFF;

	localparam logic [1:0]  WORDS_ONE = 2'h1;
	localparam logic [1:0]  WORDS_INC = 2'h1;

	localparam int unsigned OPC_LSB   = 12;
	localparam int unsigned SREG_LSB  = 8;
	localparam int unsigned AD_BIT    = 7;
	localparam int unsigned BW_BIT    = 6;
	localparam int unsigned AS_LSB    = 4;
	localparam int unsigned DREG_LSB  = 0;
	localparam int unsigned SUB_LSB   = 7;
	localparam int unsigned JTOP_LSB  = 13;

	localparam logic [3:0]  OPC_SINGLE   = 4'h1;
	localparam logic [2:0]  JUMP_TOP     = 3'h1;
	localparam logic [3:0]  OPC_DUAL_MIN = 4'h4;
	localparam logic [2:0]  SUB_LAST     = 3'h6;

	typedef enum logic [1:0] {
		FMT_DUAL   = 2'h0,
		FMT_SINGLE = 2'h1,
		FMT_JUMP   = 2'h2,
		FMT_NONE   = 2'h3
	} fmt_t;

	typedef enum logic [2:0] {
		ST_FETCH  = 3'h0,
		ST_DECODE = 3'h1,
		ST_SRC_X  = 3'h3,
		ST_SRC_RD = 3'h2,
		ST_DST_X  = 3'h6,
		ST_DST_RD = 3'h7,
		ST_EXEC   = 3'h5,
		ST_WB     = 3'h4
	} state_t;

	typedef struct packed {
		fmt_t       fmt;
		logic       legal;
		logic [3:0] opcode;
		logic [2:0] sub_op;
		logic       byte_op;
		logic [1:0] src_mode_bits;
		logic [3:0] src_reg;
		logic       dst_mode;
		logic [3:0] dst_reg;
	} decoded_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic        byte_op;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        valid;
		fmt_t        fmt;
		logic [3:0]  opcode;
		logic [2:0]  sub_op;
		logic        byte_op;
		logic [15:0] instr;
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] pc;
		logic [1:0]  words;
	} exec_req_t;

endpackage
`default_nettype wire

// ==== rtl/instr_decode.sv ====
`default_nettype none
module instr_decode
	import cpu_decode_pkg::*;
(
	input  wire logic [15:0] instr,
	output decoded_t         dec
);

	logic [3:0] opc;
	logic [2:0] sub;

	assign opc = instr[OPC_LSB +: 4];
	assign sub = instr[SUB_LSB +: 3];

	always_comb begin
		dec               = '0;
		dec.opcode        = opc;
		dec.sub_op        = sub;
		dec.dst_reg       = instr[DREG_LSB +: 4];
		dec.src_mode_bits = instr[AS_LSB +: 2];
		if (opc >= OPC_DUAL_MIN) begin
			// Twelve dual-operand opcodes
			dec.fmt      = FMT_DUAL;
			dec.legal    = 1'b1;
			dec.src_reg  = instr[SREG_LSB +: 4];
			dec.dst_mode = instr[AD_BIT];
			dec.byte_op  = instr[BW_BIT];
		end else if (instr[JTOP_LSB +: 3] == JUMP_TOP) begin
			// Eight jump conditions
			dec.fmt   = FMT_JUMP;
			dec.legal = 1'b1;
		end else if (opc == OPC_SINGLE) begin
			// Seven single-operand opcodes
			dec.fmt     = FMT_SINGLE;
			dec.legal   = (sub <= SUB_LAST);
			dec.src_reg = instr[DREG_LSB +: 4];
			dec.byte_op = instr[BW_BIT];
		end else begin
			dec.fmt = FMT_NONE;
		end
	end

endmodule // instr_decode
`default_nettype wire

// ==== rtl/cpu_operand_mode_and_format_decode.sv ====
`default_nettype none
module cpu_operand_mode_and_format_decode
	import cpu_decode_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	output mem_req_t         mem_req,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ready,
	output exec_req_t        exec_req,
	input  wire logic        exec_done,
	input  wire logic        exec_write,
	input  wire logic [15:0] exec_result,
	output logic             illegal_op
);

	state_t      state;
	state_t      next_state;
	logic [15:0] regs [REG_COUNT];
	logic [15:0] next_regs [REG_COUNT];
	logic [15:0] ir;
	logic [15:0] next_ir;
	logic [15:0] src_val;
	logic [15:0] next_src_val;
	logic [15:0] src_addr;
	logic [15:0] next_src_addr;
	logic [15:0] dst_val;
	logic [15:0] next_dst_val;
	logic [15:0] dst_addr;
	logic [15:0] next_dst_addr;
	logic        src_mem;
	logic        next_src_mem;
	logic [1:0]  words;
	logic [1:0]  next_words;
	logic        next_illegal;
	mem_req_t    mreq;

	decoded_t    dec;
	logic        cg_hit;
	logic [15:0] cg_val;
	logic [15:0] auto_step;
	logic [15:0] base_s;
	logic [15:0] base_d;
	logic [15:0] rd_val;
	logic [15:0] dreg_val;
	logic [15:0] sreg_val;
	state_t      after_src;
	logic        tgt_mem;
	logic [3:0]  tgt_reg;
	logic [15:0] tgt_addr;
	logic [15:0] res_sized;

	instr_decode u_decode (
		.instr (ir),
		.dec   (dec)
	);

	// Constant generators on the status and constant registers
	always_comb begin
		cg_hit = 1'b0;
		cg_val = CG_ZERO;
		if (dec.src_reg == REG_CG) begin
			cg_hit = 1'b1;
			case (dec.src_mode_bits)
				MODE_REG: cg_val = CG_ZERO;
				MODE_IDX: cg_val = CG_ONE;
				MODE_IND: cg_val = CG_TWO;
				default:  cg_val = CG_ALL;
			endcase
		end else if (dec.src_reg == REG_SR) begin
			case (dec.src_mode_bits)
				MODE_IND: begin
					cg_hit = 1'b1;
					cg_val = CG_FOUR;
				end
				MODE_AUTO: begin
					cg_hit = 1'b1;
					cg_val = CG_EIGHT;
				end
				default: begin
					cg_hit = 1'b0;
					cg_val = CG_ZERO;
				end
			endcase
		end
	end

	// Program counter steps by a word; others by operand size
	always_comb begin
		if (dec.src_reg == REG_PC) begin
			auto_step = STEP_WORD;
		end else if (dec.byte_op) begin
			auto_step = STEP_BYTE;
		end else begin
			auto_step = STEP_WORD;
		end
	end

	// Index bases; the status register gives absolute addressing
	assign base_s = (dec.src_reg == REG_SR) ? WORD_ZERO : regs[dec.src_reg];
	assign base_d = (dec.dst_reg == REG_SR) ? WORD_ZERO : regs[dec.dst_reg];

	// Byte reads take the lane named by the address
	always_comb begin
		if (!mreq.byte_op) begin
			rd_val = mem_rdata;
		end else if (mreq.addr[0]) begin
			rd_val = {8'h00, mem_rdata[15:8]};
		end else begin
			rd_val = {8'h00, mem_rdata[7:0]};
		end
	end

	assign sreg_val = dec.byte_op ? (regs[dec.src_reg] & BYTE_MASK)
		: regs[dec.src_reg];
	assign dreg_val = dec.byte_op ? (regs[dec.dst_reg] & BYTE_MASK)
		: regs[dec.dst_reg];
	assign res_sized = dec.byte_op ? (exec_result & BYTE_MASK)
		: exec_result;

	// Where the source phase hands over
	always_comb begin
		if (dec.fmt == FMT_DUAL && dec.dst_mode) begin
			after_src = ST_DST_X;
		end else begin
			after_src = ST_EXEC;
		end
	end

	// Write-back target for each format
	always_comb begin
		case (dec.fmt)
			FMT_DUAL: begin
				tgt_mem  = dec.dst_mode;
				tgt_reg  = dec.dst_reg;
				tgt_addr = dst_addr;
			end
			FMT_SINGLE: begin
				tgt_mem  = src_mem;
				tgt_reg  = dec.src_reg;
				tgt_addr = src_addr;
			end
			default: begin
				tgt_mem  = 1'b0;
				tgt_reg  = REG_PC;
				tgt_addr = WORD_ZERO;
			end
		endcase
	end

	always_comb begin
		next_state    = state;
		next_regs     = regs;
		next_ir       = ir;
		next_src_val  = src_val;
		next_src_addr = src_addr;
		next_dst_val  = dst_val;
		next_dst_addr = dst_addr;
		next_src_mem  = src_mem;
		next_words    = words;
		next_illegal  = 1'b0;
		mreq          = '0;
		case (state)
			ST_FETCH: begin
				mreq.addr = regs[REG_PC];
				mreq.rd   = 1'b1;
				if (mem_ready) begin
					next_ir            = mem_rdata;
					next_regs[REG_PC]  = regs[REG_PC] + STEP_WORD;
					next_words         = WORDS_ONE;
					next_state         = ST_DECODE;
				end
			end
			ST_DECODE: begin
				next_src_mem = 1'b0;
				next_dst_val = dreg_val;
				if (!dec.legal) begin
					next_illegal = 1'b1;
					next_state   = ST_FETCH;
				end else if (dec.fmt == FMT_JUMP) begin
					next_src_val = WORD_ZERO;
					next_state   = ST_EXEC;
				end else if (cg_hit) begin
					// No extra word for a generated constant
					next_src_val = dec.byte_op
						? (cg_val & BYTE_MASK) : cg_val;
					next_state   = after_src;
				end else begin
					case (dec.src_mode_bits)
						MODE_REG: begin
							next_src_val = sreg_val;
							next_state   = after_src;
						end
						MODE_IDX: begin
							next_src_mem = 1'b1;
							next_state   = ST_SRC_X;
						end
						default: begin
							// Indirect, autoincrement, immediate
							next_src_mem  = 1'b1;
							next_src_addr = regs[dec.src_reg];
							next_state    = ST_SRC_RD;
						end
					endcase
				end
			end
			ST_SRC_X: begin
				mreq.addr = regs[REG_PC];
				mreq.rd   = 1'b1;
				if (mem_ready) begin
					next_src_addr     = mem_rdata + base_s;
					next_regs[REG_PC] = regs[REG_PC] + STEP_WORD;
					next_words        = words + WORDS_INC;
					next_state        = ST_SRC_RD;
				end
			end
			ST_SRC_RD: begin
				mreq.addr    = src_addr;
				mreq.rd      = 1'b1;
				mreq.byte_op = dec.byte_op;
				if (mem_ready) begin
					next_src_val = rd_val;
					next_dst_val = dreg_val;
					if (dec.src_mode_bits == MODE_AUTO) begin
						// Bump only once the operand is in
						next_regs[dec.src_reg] =
							regs[dec.src_reg] + auto_step;
						if (dec.src_reg == REG_PC) begin
							next_words = words + WORDS_INC;
						end
					end
					next_state = after_src;
				end
			end
			ST_DST_X: begin
				mreq.addr = regs[REG_PC];
				mreq.rd   = 1'b1;
				if (mem_ready) begin
					// Any address is taken as destination
					next_dst_addr     = mem_rdata + base_d;
					next_regs[REG_PC] = regs[REG_PC] + STEP_WORD;
					next_words        = words + WORDS_INC;
					next_state        = ST_DST_RD;
				end
			end
			ST_DST_RD: begin
				mreq.addr    = dst_addr;
				mreq.rd      = 1'b1;
				mreq.byte_op = dec.byte_op;
				if (mem_ready) begin
					next_dst_val = rd_val;
					next_state   = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (exec_done) begin
					if (!exec_write) begin
						next_state = ST_FETCH;
					end else if (tgt_mem) begin
						next_dst_val = res_sized;
						next_state   = ST_WB;
					end else begin
						next_regs[tgt_reg] = res_sized;
						next_state         = ST_FETCH;
					end
				end
			end
			ST_WB: begin
				mreq.addr    = tgt_addr;
				mreq.wr      = 1'b1;
				mreq.byte_op = dec.byte_op;
				mreq.wdata   = dec.byte_op
					? {dst_val[7:0], dst_val[7:0]} : dst_val;
				if (mem_ready) begin
					next_state = ST_FETCH;
				end
			end
			default: begin
				next_state = ST_FETCH;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state      <= ST_FETCH;
			ir         <= WORD_ZERO;
			src_val    <= WORD_ZERO;
			src_addr   <= WORD_ZERO;
			dst_val    <= WORD_ZERO;
			dst_addr   <= WORD_ZERO;
			src_mem    <= 1'b0;
			words      <= WORDS_ONE;
			illegal_op <= 1'b0;
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= WORD_ZERO;
			end
			regs[REG_PC] <= RESET_PC;
		end else begin
			state      <= next_state;
			regs       <= next_regs;
			ir         <= next_ir;
			src_val    <= next_src_val;
			src_addr   <= next_src_addr;
			dst_val    <= next_dst_val;
			dst_addr   <= next_dst_addr;
			src_mem    <= next_src_mem;
			words      <= next_words;
			illegal_op <= next_illegal;
		end
	end

	assign mem_req = mreq;

	always_comb begin
		exec_req         = '0;
		exec_req.valid   = (state == ST_EXEC);
		exec_req.fmt     = dec.fmt;
		exec_req.opcode  = dec.opcode;
		exec_req.sub_op  = dec.sub_op;
		exec_req.byte_op = dec.byte_op;
		exec_req.instr   = ir;
		exec_req.src     = src_val;
		exec_req.dst     = dst_val;
		exec_req.pc      = regs[REG_PC];
		exec_req.words   = words;
	end

endmodule // cpu_operand_mode_and_format_decode
`default_nettype wire

// ==== tb/cpu_decode_monitor.sv ====
`default_nettype none
module cpu_decode_monitor
	import cpu_decode_pkg::*;
(
	input wire logic      clk_sys,
	input wire logic      rst,
	input wire mem_req_t  mem_req,
	input wire logic      mem_ready,
	input wire exec_req_t exec_req,
	input wire logic      exec_done,
	input wire logic      illegal_op
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	logic v;
	assign v = exec_req.valid;

	property p_mem_hold;
		mem_req.rd && !mem_ready |=> mem_req.rd && $stable(mem_req.addr);
	endproperty
	a_mem_hold: assert property (p_mem_hold)
		else $error("memory read dropped before ready");
	property p_align;
		(mem_req.rd || mem_req.wr) && !mem_req.byte_op |-> !mem_req.addr[0];
	endproperty
	a_align: assert property (p_align)
		else $error("odd word access");
	property p_exec_hold;
		v && !exec_done |=> v && $stable(exec_req.src) && $stable(exec_req.dst);
	endproperty
	a_exec_hold: assert property (p_exec_hold)
		else $error("exec operands moved");
	property p_fmt;
		v |-> (exec_req.fmt == FMT_DUAL) ==
			(exec_req.instr[15:12] >= OPC_DUAL_MIN);
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("dual format mismatch");
	property p_jump;
		v && exec_req.fmt == FMT_JUMP |-> exec_req.instr[15:13] == JUMP_TOP
			&& !exec_req.byte_op && exec_req.words == 2'h1;
	endproperty
	a_jump: assert property (p_jump)
		else $error("bad jump request");
	property p_bw;
		v && exec_req.fmt != FMT_JUMP |-> exec_req.byte_op == exec_req.instr[6];
	endproperty
	a_bw: assert property (p_bw)
		else $error("size bit not honoured");
	property p_byte_src;
		v && exec_req.byte_op |-> exec_req.src[15:8] == 8'h00;
	endproperty
	a_byte_src: assert property (p_byte_src)
		else $error("byte source not zero extended");
	property p_words;
		v |-> exec_req.words inside {2'h1, 2'h2, 2'h3};
	endproperty
	a_words: assert property (p_words)
		else $error("bad instruction length");
	property p_pc;
		v |-> !exec_req.pc[0];
	endproperty
	a_pc: assert property (p_pc)
		else $error("odd program counter");
	property p_ill;
		illegal_op |-> !v ##1 !illegal_op;
	endproperty
	a_ill: assert property (p_ill)
		else $error("illegal flag not a pulse");
	property p_fields;
		v |-> exec_req.opcode == exec_req.instr[15:12]
			&& exec_req.sub_op == exec_req.instr[9:7];
	endproperty
	a_fields: assert property (p_fields)
		else $error("opcode fields differ from instruction");

	c_jump: cover property (v && exec_req.fmt == FMT_JUMP);
	c_byte: cover property (v && exec_req.byte_op);
	c_ill: cover property (illegal_op);
endmodule // cpu_decode_monitor

bind cpu_operand_mode_and_format_decode cpu_decode_monitor u_mon (
	.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_ready(mem_ready),
	.exec_req(exec_req), .exec_done(exec_done), .illegal_op(illegal_op));
`default_nettype wire

// ==== tb/mem_partner.sv ====
`default_nettype none
module mem_partner
	import cpu_decode_pkg::*;
(
	input  wire logic     clk_sys,
	input  wire mem_req_t mem_req,
	input  wire logic     stall,
	output logic          mem_ready,
	output logic [15:0]   mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:511];
	logic        go;
	assign go = (mem_req.rd | mem_req.wr) & ~stall;
	initial begin
		mem_ready = 1'b0;
		mem_rdata = 16'h0000;
	end
	always @(negedge clk_sys) begin
		mem_ready <= go;
		if (go && mem_req.rd) begin
			mem_rdata <= mem[mem_req.addr[9:1]];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
		// Every address completes; lane picked by low address bit
		if (go && mem_req.wr) begin
			if (!mem_req.byte_op) begin
				mem[mem_req.addr[9:1]] <= mem_req.wdata;
			end else if (mem_req.addr[0]) begin
				mem[mem_req.addr[9:1]][15:8] <= mem_req.wdata[15:8];
			end else begin
				mem[mem_req.addr[9:1]][7:0] <= mem_req.wdata[7:0];
			end
		end
	end
endmodule // mem_partner
`default_nettype wire

// ==== tb/cpu_operand_mode_and_format_decode_tb_top.sv ====
`default_nettype none
module cpu_operand_mode_and_format_decode_tb_top
	import cpu_decode_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        ill;
		fmt_t        fmt;
		logic        byte_op;
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] pc;
		logic [1:0]  words;
	} note_t;
	logic        clk_sys, rst, mem_ready, exec_done, exec_write;
	logic        illegal_op, stall, halt, seen, vprev;
	logic [15:0] mem_rdata, exec_result, d0, d1, d2;
	logic [31:0] seed;
	mem_req_t    mem_req;
	exec_req_t   exec_req;
	note_t       q[$];
	int          error_cnt, n_checks, cyc, i;

	cpu_operand_mode_and_format_decode u_dut (.clk_sys(clk_sys), .rst(rst),
		.mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
		.exec_req(exec_req), .exec_done(exec_done), .exec_write(exec_write),
		.exec_result(exec_result), .illegal_op(illegal_op));
	mem_partner u_mem (.clk_sys(clk_sys), .mem_req(mem_req), .stall(stall),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic note(input logic l, input fmt_t f, input logic b,
		input logic [15:0] s, input logic [15:0] d, input logic [15:0] p,
		input logic [1:0] w);
		q.push_back(note_t'{l, f, b, s, d, p, w});
	endtask

	task automatic bad(input string m);
		error_cnt++;
		$display("ERROR %0t %s", $time, m);
	endtask

	task automatic chk_exec(input note_t e);
		n_checks++;
		if (e.ill !== 1'b0 || exec_req.fmt !== e.fmt || exec_req.pc !== e.pc
			|| exec_req.byte_op !== e.byte_op || exec_req.src !== e.src
			|| exec_req.words !== e.words
			|| (e.fmt == FMT_DUAL && exec_req.dst !== e.dst)) begin
			bad("exec request fields differ");
		end
	endtask

	task automatic chk_ill(input note_t e);
		n_checks++;
		if (e.ill !== 1'b1) begin
			bad("unexpected illegal flag");
		end
	endtask

	task automatic chk_mem(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad("memory word differs");
		end
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Execution unit: random latency, jumps return the branch target
	always @(negedge clk_sys) begin
		seed = xs(seed);
		stall <= halt | (seed[1:0] == 2'h0);
		exec_done <= exec_req.valid & vprev & ~exec_done & seed[2];
		vprev <= exec_req.valid;
		exec_result <= (exec_req.fmt == FMT_JUMP) ? exec_req.pc +
			{{5{exec_req.instr[9]}}, exec_req.instr[9:0], 1'b0} : exec_req.src;
	end

	// Result watcher
	always @(negedge clk_sys) begin
		if (!rst && exec_req.valid === 1'b1 && !seen) begin
			seen = 1'b1;
			if (q.size() == 0) bad("unexpected exec request");
			else chk_exec(q.pop_front());
			if (q.size() == 0) halt = 1'b1;
		end
		if (!rst && illegal_op === 1'b1) begin
			if (q.size() == 0) bad("unexpected illegal flag");
			else chk_ill(q.pop_front());
		end
		if (exec_done === 1'b1) seen = 1'b0;
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			bad("timeout");
			end_sim;
		end
	end

	initial begin
		rst = 1'b1;
		stall = 1'b0;
		halt = 1'b0;
		seen = 1'b0;
		exec_done = 1'b0;
		vprev = 1'b0;
		exec_write = 1'b1;
		exec_result = 16'h0000;
		seed = xs(32'h39C0);
		d0 = seed[15:0];
		d1 = seed[31:16];
		seed = xs(seed);
		d2 = seed[15:0];
		for (i = 0; i < 512; i++) u_mem.mem[i] = 16'h0000;
		u_mem.mem[0:15] = '{16'h403A, 16'h0100, 16'h4A3B, 16'h4A7C,
			16'h4A7D, 16'h407E, 16'h0012, 16'h4315, 16'h4235, 16'h5325,
			16'h1005, 16'h4B82, 16'h0200, 16'h0000, 16'h1380, 16'h3C00};
		u_mem.mem[128] = d0;
		u_mem.mem[129] = d1;
		u_mem.mem[256] = d2;
		note(0, FMT_DUAL, 0, 16'h0100, 16'h0, 16'h4, 2'h2);
		note(0, FMT_DUAL, 0, d0, 16'h0, 16'h6, 2'h1);
		note(0, FMT_DUAL, 1, {8'h00, d1[7:0]}, 16'h0, 16'h8, 2'h1);
		note(0, FMT_DUAL, 1, {8'h00, d1[15:8]}, 16'h0, 16'hA, 2'h1);
		note(0, FMT_DUAL, 1, 16'h0012, 16'h0, 16'hE, 2'h2);
		note(0, FMT_DUAL, 0, 16'h0001, 16'h0, 16'h10, 2'h1);
		note(0, FMT_DUAL, 0, 16'h0008, 16'h1, 16'h12, 2'h1);
		note(0, FMT_DUAL, 0, 16'h0002, 16'h8, 16'h14, 2'h1);
		note(0, FMT_SINGLE, 0, 16'h0002, 16'h0, 16'h16, 2'h1);
		note(0, FMT_DUAL, 0, d0, d2, 16'h1A, 2'h2);
		note(1, FMT_NONE, 0, 16'h0, 16'h0, 16'h0, 2'h0);
		note(1, FMT_NONE, 0, 16'h0, 16'h0, 16'h0, 2'h0);
		note(0, FMT_JUMP, 0, 16'h0, 16'h0, 16'h20, 2'h1);
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		while (q.size() != 0) @(negedge clk_sys);
		repeat (4) @(negedge clk_sys);
		chk_mem(u_mem.mem[256], d0);
		end_sim;
	end
endmodule // cpu_operand_mode_and_format_decode_tb_top
`default_nettype wire
